// *** common/gpio_port_pkg.sv ***
package gpio_port_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_DATA_LATCH = 16'hFFDB;
  localparam logic [15:0] IDX_DIRECTION  = 16'hFFEB;
  localparam logic [15:0] IDX_SEG_SELECT = 16'hFF40;

  // Reset values and fixed read values.
  localparam logic [7:0]  DATA_LATCH_RST = 8'h00;
  localparam logic [7:0]  DIRECTION_RST  = 8'h00;
  localparam logic [3:0]  SEG_SELECT_RST = 4'h0;
  localparam logic [7:0]  DIRECTION_READ = 8'hFF;
  localparam logic [31:0] BUS_ZERO       = 32'h0000_0000;

  // Field layout of the segment-select register.
  localparam int SEG_SEL_LSB = 0;
  localparam int SEG_SEL_W   = 4;

  // Operating modes as seen by the port.
  typedef enum logic [2:0] {
    PWR_ACTIVE   = 3'b000,
    PWR_LOW_RUN  = 3'b001,
    PWR_SLEEP    = 3'b010,
    PWR_LOW_HALT = 3'b011,
    PWR_TIME_HLT = 3'b100,
    PWR_STANDBY  = 3'b101
  } power_mode_e;

  // Everything but the power mode that the pin stage needs to decide one pin.
  typedef struct packed {
    logic [7:0] direction;
    logic [7:0] latch;
    logic [7:0] segment;
    logic       gp_mode;
  } pin_ctrl_s;

  // One Wishbone request as seen by the slave.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] index;
    logic        lane0;
    logic [7:0]  wdata;
  } wb_req_s;

endpackage : gpio_port_pkg

// *** core/gpio_pin_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_stage
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8
)
(
  // Clock, reset and enable
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        ce_i,
  // Control
  input  wire  power_mode_e mode_i,
  input  wire  pin_ctrl_s   ctrl_i,
  // Pins
  output logic [PINS-1:0]   pin_o,
  output logic [PINS-1:0]   pin_oe_o
);

  logic [PINS-1:0] pin_reg;
  logic [PINS-1:0] pin_next;
  logic [PINS-1:0] oe_reg;
  logic [PINS-1:0] oe_next;

  ////////////////////////////////////////////////////////////////////////////

  genvar n;
  generate
    for (n = 0; n < PINS; n++)
    begin : g_pin
      always_comb
      begin
        pin_next[n] = pin_reg[n];
        oe_next[n]  = oe_reg[n];
        case (mode_i)
          PWR_ACTIVE, PWR_LOW_RUN:
          begin
            if (ctrl_i.gp_mode)
            begin
              pin_next[n] = ctrl_i.latch[n];
              oe_next[n]  = ctrl_i.direction[n];
            end
            else
            begin
              pin_next[n] = ctrl_i.segment[n];
              oe_next[n]  = 1'b1;
            end
          end
          PWR_STANDBY:
          begin
            oe_next[n] = 1'b0;
          end
          default:
          begin
            // Sleep and both halt modes keep the last drive untouched.
            pin_next[n] = pin_reg[n];
            oe_next[n]  = oe_reg[n];
          end
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_reg <= '0;
      oe_reg  <= '0;
    end
    else if (ce_i)
    begin
      pin_reg <= pin_next;
      oe_reg  <= oe_next;
    end
  end

  assign pin_o    = pin_reg;
  assign pin_oe_o = oe_reg;

endmodule : gpio_pin_stage
`default_nettype wire

// *** core/gpio_port.sv ***
// Functional notes
// - An 8-bit data latch holds one value per port pin.
// - Reading a bit whose direction is output returns the latched value.
// - Reading a bit whose direction is input returns the sampled pin level.
// - Reset clears the data latch to zero.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register is write-only and always reads back all ones.
// - Reset clears the direction register, so every pin starts as input.
// - Direction and data only act while segment select grants port use.
// - Select 000x gives port pins; any other value drives segment outputs.
// - Pins float in reset and standby, hold in sleep and halts.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS  = 8,
  parameter int ADR_W = 18
)
(
  // Clock, reset and enable
  input  wire  logic              SYS_CLK_I,
  input  wire  logic              RST_I,
  input  wire  logic              CE_I,
  // Wishbone slave
  input  wire  logic              CYC_I,
  input  wire  logic              STB_I,
  input  wire  logic              WE_I,
  input  wire  logic [ADR_W-1:0]  ADR_I,
  input  wire  logic [3:0]        SEL_I,
  input  wire  logic [31:0]       DAT_I,
  output logic       [31:0]       DAT_O,
  output logic                    ACK_O,
  // System and display controller
  input  wire  power_mode_e       POWER_MODE_I,
  input  wire  logic [PINS-1:0]   LCD_SEGMENT_DRIVE_I,
  // Port pins
  input  wire  logic [PINS-1:0]   GP_PIN_I,
  output logic       [PINS-1:0]   GP_PIN_O,
  output logic       [PINS-1:0]   GP_PIN_OE_O
);

  wb_req_s          req;
  logic             hit_latch;
  logic             hit_dir;
  logic             hit_sel;
  logic             take;
  logic             commit;
  logic [31:0]      rdata;
  logic             ack_reg;
  logic             ack_next;
  logic [31:0]      dat_reg;
  logic [31:0]      dat_next;
  logic [PINS-1:0]  port_pin_data_latch_reg;
  logic [PINS-1:0]  port_pin_data_latch_next;
  logic [PINS-1:0]  port_pin_direction_reg;
  logic [PINS-1:0]  port_pin_direction_next;
  logic [3:0]       segment_select_field_reg;
  logic [3:0]       segment_select_field_next;
  pin_ctrl_s        pin_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  assign req.cyc   = CYC_I;
  assign req.stb   = STB_I;
  assign req.we    = WE_I;
  assign req.index = ADR_I[ADR_W-1:2];
  assign req.lane0 = SEL_I[0];
  assign req.wdata = DAT_I[7:0];

  always_comb
  begin
    hit_latch = 1'b0;
    hit_dir   = 1'b0;
    hit_sel   = 1'b0;
    if (req.index == IDX_DATA_LATCH)
    begin
      hit_latch = 1'b1;
    end
    else if (req.index == IDX_DIRECTION)
    begin
      hit_dir = 1'b1;
    end
    else if (req.index == IDX_SEG_SELECT)
    begin
      hit_sel = 1'b1;
    end
  end

  // A request is answered one cycle after it appears; the write lands on the
  // edge where the master sees the acknowledge, so it happens exactly once.
  assign take   = req.cyc && req.stb && !ack_reg;
  assign commit = req.cyc && req.stb && ack_reg && req.we && req.lane0;

  ////////////////////////////////////////////////////////////////////////////
  // Read data. Unmapped addresses are acknowledged and read as zero.

  always_comb
  begin
    rdata = BUS_ZERO;
    if (hit_latch)
    begin
      rdata[PINS-1:0] = (port_pin_direction_reg & port_pin_data_latch_reg)
                      | (~port_pin_direction_reg & GP_PIN_I);
    end
    else if (hit_dir)
    begin
      rdata[7:0] = DIRECTION_READ;
    end
    else if (hit_sel)
    begin
      rdata[SEG_SEL_LSB +: SEG_SEL_W] = segment_select_field_reg;
    end
  end

  always_comb
  begin
    ack_next = take;
    dat_next = dat_reg;
    if (take && !req.we)
    begin
      dat_next = rdata;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ack_reg <= 1'b0;
      dat_reg <= BUS_ZERO;
    end
    else if (CE_I)
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_comb
  begin
    port_pin_data_latch_next  = port_pin_data_latch_reg;
    port_pin_direction_next   = port_pin_direction_reg;
    segment_select_field_next = segment_select_field_reg;
    if (commit && hit_latch)
    begin
      port_pin_data_latch_next = req.wdata;
    end
    else if (commit && hit_dir)
    begin
      port_pin_direction_next = req.wdata;
    end
    else if (commit && hit_sel)
    begin
      segment_select_field_next = req.wdata[SEG_SEL_LSB +: SEG_SEL_W];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      port_pin_data_latch_reg  <= DATA_LATCH_RST;
      port_pin_direction_reg   <= DIRECTION_RST;
      segment_select_field_reg <= SEG_SELECT_RST;
    end
    else if (CE_I)
    begin
      port_pin_data_latch_reg  <= port_pin_data_latch_next;
      port_pin_direction_reg   <= port_pin_direction_next;
      segment_select_field_reg <= segment_select_field_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. The stage adds one cycle so every pin output is a flip-flop.

  assign pin_ctrl.direction = port_pin_direction_reg;
  assign pin_ctrl.latch     = port_pin_data_latch_reg;
  assign pin_ctrl.segment   = LCD_SEGMENT_DRIVE_I;
  assign pin_ctrl.gp_mode   = (segment_select_field_reg[3:1] == 3'b000);

  gpio_pin_stage #(
    .PINS     (PINS)
  ) u_pin_stage (
    .clk_i    (SYS_CLK_I),
    .rst_i    (RST_I),
    .ce_i     (CE_I),
    .mode_i   (POWER_MODE_I),
    .ctrl_i   (pin_ctrl),
    .pin_o    (GP_PIN_O),
    .pin_oe_o (GP_PIN_OE_O)
  );

  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge SYS_CLK_I);
  endclocking

  default disable iff (RST_I);

  logic functional;
  assign functional = (POWER_MODE_I == PWR_ACTIVE) || (POWER_MODE_I == PWR_LOW_RUN);

  latch_reset_clear_a: assert property (
    @(posedge SYS_CLK_I) disable iff (1'b0)
    $fell(RST_I) |-> (port_pin_data_latch_reg == DATA_LATCH_RST))
    else $error("Data latch not cleared by reset.");

  dir_reset_clear_a: assert property (
    @(posedge SYS_CLK_I) disable iff (1'b0)
    $fell(RST_I) |-> (port_pin_direction_reg == DIRECTION_RST) && (GP_PIN_OE_O == '0))
    else $error("Direction not cleared by reset.");

  reset_float_a: assert property (
    @(posedge SYS_CLK_I) disable iff (1'b0)
    RST_I |-> (GP_PIN_OE_O == '0))
    else $error("Pins driven during reset.");

  read_output_bits_a: assert property (
    (CE_I && take && !req.we && hit_latch) |=>
      ACK_O && ((DAT_O[PINS-1:0] & $past(port_pin_direction_reg))
             == ($past(port_pin_data_latch_reg) & $past(port_pin_direction_reg))))
    else $error("Output bit read did not return the latch.");

  read_input_bits_a: assert property (
    (CE_I && take && !req.we && hit_latch) |=>
      ((DAT_O[PINS-1:0] & ~$past(port_pin_direction_reg))
        == ($past(GP_PIN_I) & ~$past(port_pin_direction_reg))))
    else $error("Input bit read did not return the pin.");

  dir_reads_ones_a: assert property (
    (CE_I && take && !req.we && hit_dir) |=> ACK_O && (DAT_O == 32'h0000_00FF))
    else $error("Direction read was not all ones.");

  latch_write_store_a: assert property (
    (CE_I && commit && hit_latch) |=> (port_pin_data_latch_reg == $past(DAT_I[7:0])))
    else $error("Latch write lost.");

  dir_write_store_a: assert property (
    (CE_I && commit && hit_dir) |=> (port_pin_direction_reg == $past(DAT_I[7:0])))
    else $error("Direction write lost.");

  gp_drive_follow_a: assert property (
    (CE_I && functional && pin_ctrl.gp_mode) |=>
      (GP_PIN_O == $past(port_pin_data_latch_reg))
      && (GP_PIN_OE_O == $past(port_pin_direction_reg)))
    else $error("Port pin does not follow latch and direction.");

  seg_drive_own_a: assert property (
    (CE_I && functional && !pin_ctrl.gp_mode) |=>
      (GP_PIN_OE_O == '1) && (GP_PIN_O == $past(LCD_SEGMENT_DRIVE_I)))
    else $error("Segment mode pin not driving segment data.");

  standby_float_a: assert property (
    (CE_I && POWER_MODE_I == PWR_STANDBY) |=> (GP_PIN_OE_O == '0))
    else $error("Pins driven in standby.");

  halt_hold_pins_a: assert property (
    (CE_I && !functional && POWER_MODE_I != PWR_STANDBY) |=>
      $stable(GP_PIN_O) && $stable(GP_PIN_OE_O))
    else $error("Pins changed in a holding mode.");

  ack_single_pulse_a: assert property (
    ACK_O |=> !ACK_O)
    else $error("Acknowledge longer than one cycle.");

  latch_write_c: cover property (CE_I && commit && hit_latch);
  dir_read_c:    cover property (CE_I && take && !req.we && hit_dir);
  seg_mode_c:    cover property (functional && !pin_ctrl.gp_mode ##1 GP_PIN_OE_O == '1);
  sleep_hold_c:  cover property (POWER_MODE_I == PWR_SLEEP && GP_PIN_OE_O != '0);

endmodule : gpio_port
`default_nettype wire

// *** tb/pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
  // Port side
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] o_i,
  // Outside world
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  // The outside world always drives, but a driving port wins on the wire.
  always_comb pin_o = (oe_i & o_i) | (~oe_i & ext_i);
endmodule : pin_partner
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpio_port_pkg::*;
  logic        clk = 1'b0;
  // Reset starts low and rises at time zero as a real edge, so the asynchronous
  // reset branches run before the first clock edge samples any output.
  logic        rst = 1'b0;
  logic        ce  = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [17:0] adr = 18'h0_0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd  = 32'h0000_0000;
  logic [31:0] dat;
  logic [31:0] rd;
  logic        ack;
  power_mode_e pm  = PWR_ACTIVE;
  logic [7:0]  lcd_segment_drive = 8'h00;
  logic [7:0]  ext = 8'hA5;
  logic [7:0]  pin;
  logic [7:0]  po;
  logic [7:0]  poe;
  logic [7:0]  dr;
  logic [7:0]  lt;
  logic [31:0] lf  = 32'h2bab_4fc9;
  int          bad_count = 0;
  int          tests_run = 0;
  power_mode_e hm[3] = '{PWR_SLEEP, PWR_LOW_HALT, PWR_TIME_HLT};

  always #5 clk = ~clk;

  gpio_port gpio_port_i (
    .SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wd), .DAT_O(dat), .ACK_O(ack),
    .POWER_MODE_I(pm), .LCD_SEGMENT_DRIVE_I(lcd_segment_drive), .GP_PIN_I(pin), .GP_PIN_O(po),
    .GP_PIN_OE_O(poe)
  );
  pin_partner pin_partner_i (.oe_i(poe), .o_i(po), .ext_i(ext), .pin_o(pin));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], 1'b0} ^ (l[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : nxt

  function automatic logic [7:0] exp_rd(input logic [7:0] dv, input logic [7:0] lv,
                                        input logic [7:0] ev);
    return (dv & lv) | (~dv & ev);
  endfunction : exp_rd

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_pin

  // The request is held until ack is sampled high or 50 cycles pass, so no exact cycle count is assumed.
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    wd  <= {24'h00_0000, v};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      bad_count++;
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic summarize;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk_pin(8'h00, poe);
    wb(1'b0, IDX_DATA_LATCH, 8'h00);
    chk_reg({24'h00_0000, 8'hA5}, rd);
    wb(1'b0, IDX_DIRECTION, 8'h00);
    chk_reg({24'h00_0000, DIRECTION_READ}, rd);
    wb(1'b1, IDX_DIRECTION, 8'hFF);
    wb(1'b0, IDX_DATA_LATCH, 8'h00);
    chk_reg(32'h0000_0000, rd);
    wb(1'b0, 16'h0100, 8'h00);
    chk_reg(BUS_ZERO, rd);
    repeat (20)
    begin
      lf = nxt(lf);
      dr = lf[7:0];
      lt = lf[15:8];
      ext <= lf[23:16];
      lcd_segment_drive <= lf[31:24];
      wb(1'b1, IDX_DIRECTION, dr);
      wb(1'b1, IDX_DATA_LATCH, lt);
      wb(1'b0, IDX_DATA_LATCH, 8'h00);
      chk_reg({24'h00_0000, exp_rd(dr, lt, lf[23:16])}, rd);
      chk_pin(dr, poe);
      chk_pin(dr & lt, dr & po);
    end
    for (int s = 0; s < 16; s++)
    begin
      wb(1'b1, IDX_SEG_SELECT, s[7:0]);
      repeat (3) @(posedge clk);
      chk_pin((s < 2) ? dr : 8'hFF, poe);
      chk_pin((s < 2) ? (dr & lt) : lcd_segment_drive, (s < 2) ? (dr & po) : po);
    end
    // With the clock enable low the pins must not follow a new segment value.
    ce  <= 1'b0;
    lcd_segment_drive <= ~lcd_segment_drive;
    repeat (3) @(posedge clk);
    chk_pin(~lcd_segment_drive, po);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk_pin(lcd_segment_drive, po);
    wb(1'b1, IDX_SEG_SELECT, 8'h00);
    wb(1'b1, IDX_DIRECTION, 8'hFF);
    for (int i = 0; i < 3; i++)
    begin
      repeat (3) @(posedge clk);
      pm <= hm[i];
      repeat (2) @(posedge clk);
      wb(1'b1, IDX_DATA_LATCH, ~lt);
      repeat (3) @(posedge clk);
      chk_pin(lt, po);
      pm <= PWR_LOW_RUN;
      lt = ~lt;
      repeat (3) @(posedge clk);
      chk_pin(lt, po);
    end
    pm <= PWR_STANDBY;
    repeat (3) @(posedge clk);
    chk_pin(8'h00, poe);
    pm <= PWR_ACTIVE;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk_pin(8'h00, poe);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_pin(8'h00, poe);
    wb(1'b1, IDX_DIRECTION, 8'hFF);
    wb(1'b0, IDX_DATA_LATCH, 8'h00);
    chk_reg(32'h0000_0000, rd);
    summarize();
  end
endmodule : testbench
`default_nettype wire
